// [include/ftc_defines.svh]
// Behaviour
// - Retention bit clear: wake loads hidden tuning values 0x31 and 0x88.
// - Retention bit set: wake loads hidden tuning values 0x35 and 0x81.
// - Tuning register reads after wake always return their reset values.
// - Attenuation code 00/01/10/11 selects 0/6/12/18 dB close-in receive attenuation.
// - Field n gives receive threshold 4(n+1) and transmit threshold 61-4n bytes.
// - Threshold exceeded when FIFO byte count is at or above threshold, each FIFO separately.
`ifndef FTC_DEFINES_SVH
`define FTC_DEFINES_SVH
`define FTC_ADDR_THR 6'h03
`define FTC_ADDR_TUNE_TWO 6'h2C
`define FTC_ADDR_TUNE_ONE 6'h2D
`define FTC_THR_RESET 8'h07
`define FTC_TUNE_ONE_RESET 8'h31
`define FTC_TUNE_TWO_RESET 8'h88
`define FTC_KEEP0_ONE 8'h31
`define FTC_KEEP0_TWO 8'h88
`define FTC_KEEP1_ONE 8'h35
`define FTC_KEEP1_TWO 8'h81
`define FTC_BIT_KEEP 6
`define FTC_ATTEN_HI 5
`define FTC_ATTEN_LO 4
`define FTC_SEL_HI 3
`define FTC_SEL_LO 0
`define FTC_RX_BASE 7'h04
`define FTC_TX_BASE 7'h3D
`define FTC_ATTEN_STEP 5'h06
`define FTC_ATTEN_MAX 5'h12
`define FTC_FIFO_BYTES 7'h40
`endif

// [include/ftc_pkg.sv]
package ftc_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] data;
    } ftc_req_t;
    typedef struct packed {
        logic [7:0] one;
        logic [7:0] two;
    } ftc_tune_t;
endpackage : ftc_pkg

// [src/ftc_fifo_threshold.sv]
`timescale 1ns/1ns
`include "ftc_defines.svh"
module ftc_fifo_threshold (
    input wire logic sys_clk,
    input wire logic srst,
    input wire ftc_pkg::ftc_req_t cfgReq,
    input wire logic sleepExit,
    input wire logic [6:0] rxCount,
    input wire logic [6:0] txCount,
    output logic [7:0] rdData,
    output ftc_pkg::ftc_tune_t analogTune,
    output logic [4:0] rxAttenDb,
    output logic rxThrHit,
    output logic txThrHit
);
    import ftc_pkg::*;

    logic [7:0] thrReg_r, thrReg_nxt;
    logic [7:0] rdData_r, rdData_nxt;
    ftc_tune_t tune_r, tune_nxt;
    logic [4:0] atten_r, atten_nxt;
    logic rxHit_r, rxHit_nxt, txHit_r, txHit_nxt;
    logic [3:0] sel;
    logic [6:0] rxThr, txThr;

    always_comb begin
        thrReg_nxt = thrReg_r;
        if (cfgReq.wr && cfgReq.addr == `FTC_ADDR_THR) begin
            thrReg_nxt = cfgReq.data;
        end
    end

    // Hidden tuning values stay off the read path, so a tuning register read after wake
    // cannot tell which retention choice was made
    // reads show reset values
    always_comb begin
        rdData_nxt = rdData_r;
        if (cfgReq.rd) begin
            unique case (cfgReq.addr)
                `FTC_ADDR_THR: rdData_nxt = thrReg_r;
                `FTC_ADDR_TUNE_ONE: rdData_nxt = `FTC_TUNE_ONE_RESET;
                `FTC_ADDR_TUNE_TWO: rdData_nxt = `FTC_TUNE_TWO_RESET;
                default: rdData_nxt = 8'h00;
            endcase
        end
    end

    always_comb begin
        tune_nxt = tune_r;
        if (sleepExit) begin
            if (thrReg_r[`FTC_BIT_KEEP]) begin
                tune_nxt.one = `FTC_KEEP1_ONE;
                tune_nxt.two = `FTC_KEEP1_TWO;
            end else begin
                tune_nxt.one = `FTC_KEEP0_ONE;
                tune_nxt.two = `FTC_KEEP0_TWO;
            end
        end
    end

    assign sel = thrReg_r[`FTC_SEL_HI:`FTC_SEL_LO];
    assign rxThr = 7'({sel, 2'b00}) + `FTC_RX_BASE;
    assign txThr = `FTC_TX_BASE - 7'({sel, 2'b00});

    always_comb begin
        atten_nxt = 5'(thrReg_r[`FTC_ATTEN_HI:`FTC_ATTEN_LO] * `FTC_ATTEN_STEP);
        rxHit_nxt = rxCount >= rxThr;
        txHit_nxt = txCount >= txThr;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            thrReg_r <= `FTC_THR_RESET;
            rdData_r <= 8'h00;
            tune_r.one <= `FTC_TUNE_ONE_RESET;
            tune_r.two <= `FTC_TUNE_TWO_RESET;
            atten_r <= 5'h00;
            rxHit_r <= 1'b0;
            txHit_r <= 1'b0;
        end else begin
            thrReg_r <= thrReg_nxt;
            rdData_r <= rdData_nxt;
            tune_r <= tune_nxt;
            atten_r <= atten_nxt;
            rxHit_r <= rxHit_nxt;
            txHit_r <= txHit_nxt;
        end
    end

    assign rdData = rdData_r;
    assign analogTune = tune_r;
    assign rxAttenDb = atten_r;
    assign rxThrHit = rxHit_r;
    assign txThrHit = txHit_r;

    // Named steps of the register port and the wake event
    sequence s_wakeKeep0;
        sleepExit && !thrReg_r[`FTC_BIT_KEEP];
    endsequence

    sequence s_wakeKeep1;
        sleepExit && thrReg_r[`FTC_BIT_KEEP];
    endsequence

    sequence s_thrWrite;
        cfgReq.wr && cfgReq.addr == `FTC_ADDR_THR;
    endsequence

    sequence s_otherWrite;
        cfgReq.wr && cfgReq.addr != `FTC_ADDR_THR;
    endsequence

    sequence s_thrRead;
        cfgReq.rd && cfgReq.addr == `FTC_ADDR_THR;
    endsequence

    sequence s_tuneOneRead;
        cfgReq.rd && cfgReq.addr == `FTC_ADDR_TUNE_ONE;
    endsequence

    sequence s_tuneTwoRead;
        cfgReq.rd && cfgReq.addr == `FTC_ADDR_TUNE_TWO;
    endsequence

    sequence s_holeRead;
        cfgReq.rd && cfgReq.addr != `FTC_ADDR_THR && cfgReq.addr != `FTC_ADDR_TUNE_ONE
            && cfgReq.addr != `FTC_ADDR_TUNE_TWO;
    endsequence

    // Wake loads and holds the hidden tuning pair
    a_wake_clear_vals: assert property (@(posedge sys_clk) disable iff (srst)
        s_wakeKeep0 |=> analogTune.one == `FTC_KEEP0_ONE && analogTune.two == `FTC_KEEP0_TWO)
        else $error("wake tuning wrong with retention clear");

    a_wake_set_vals: assert property (@(posedge sys_clk) disable iff (srst)
        s_wakeKeep1 |=> analogTune.one == `FTC_KEEP1_ONE && analogTune.two == `FTC_KEEP1_TWO)
        else $error("wake tuning wrong with retention set");

    a_tune_hold: assert property (@(posedge sys_clk) disable iff (srst)
        !sleepExit |=> $stable(analogTune))
        else $error("tuning changed without wake");

    // Read path
    a_tune_read_one: assert property (@(posedge sys_clk) disable iff (srst)
        s_tuneOneRead |=> rdData == `FTC_TUNE_ONE_RESET)
        else $error("first tuning read not reset value");

    a_tune_read_two: assert property (@(posedge sys_clk) disable iff (srst)
        s_tuneTwoRead |=> rdData == `FTC_TUNE_TWO_RESET)
        else $error("second tuning read not reset value");

    a_thr_read_back: assert property (@(posedge sys_clk) disable iff (srst)
        s_thrRead |=> rdData == $past(thrReg_r))
        else $error("threshold read wrong");

    a_hole_read: assert property (@(posedge sys_clk) disable iff (srst)
        s_holeRead |=> rdData == '0)
        else $error("unmapped read not zero");

    a_read_holds: assert property (@(posedge sys_clk) disable iff (srst)
        !cfgReq.rd |=> $stable(rdData))
        else $error("read data changed without read");

    // Write path
    a_write_takes: assert property (@(posedge sys_clk) disable iff (srst)
        s_thrWrite |=> thrReg_r == $past(cfgReq.data))
        else $error("threshold write not applied");

    a_write_other: assert property (@(posedge sys_clk) disable iff (srst)
        s_otherWrite |=> $stable(thrReg_r))
        else $error("write to other address changed threshold");

    // Attenuation
    a_atten_map: assert property (@(posedge sys_clk) disable iff (srst)
        ##1 rxAttenDb == 5'($past(thrReg_r[`FTC_ATTEN_HI:`FTC_ATTEN_LO]) * `FTC_ATTEN_STEP))
        else $error("attenuation mapping wrong");

    a_atten_bound: assert property (@(posedge sys_clk) disable iff (srst)
        rxAttenDb <= `FTC_ATTEN_MAX)
        else $error("attenuation out of range");

    // Threshold mapping
    a_rx_thr_map: assert property (@(posedge sys_clk) disable iff (srst)
        rxThr == 7'(`FTC_RX_BASE * (sel + 1)))
        else $error("rx threshold mapping wrong");

    a_tx_thr_map: assert property (@(posedge sys_clk) disable iff (srst)
        txThr == 7'(`FTC_TX_BASE - `FTC_RX_BASE * sel))
        else $error("tx threshold mapping wrong");

    // Threshold flags
    a_rx_hit: assert property (@(posedge sys_clk) disable iff (srst)
        ##1 rxThrHit == ($past(rxCount) >= $past(rxThr)))
        else $error("rx threshold flag wrong");

    a_tx_hit: assert property (@(posedge sys_clk) disable iff (srst)
        ##1 txThrHit == ($past(txCount) >= $past(txThr)))
        else $error("tx threshold flag wrong");

    a_rx_exact_hit: assert property (@(posedge sys_clk) disable iff (srst)
        rxCount == rxThr |=> rxThrHit)
        else $error("rx flag missing at equal count");

    a_tx_exact_hit: assert property (@(posedge sys_clk) disable iff (srst)
        txCount == txThr |=> txThrHit)
        else $error("tx flag missing at equal count");

    a_rx_full_hit: assert property (@(posedge sys_clk) disable iff (srst)
        rxCount >= `FTC_FIFO_BYTES |=> rxThrHit)
        else $error("rx flag missing with full fifo");

    a_rx_low_quiet: assert property (@(posedge sys_clk) disable iff (srst)
        rxCount < `FTC_RX_BASE |=> !rxThrHit)
        else $error("rx flag set below lowest threshold");

    a_tx_empty_quiet: assert property (@(posedge sys_clk) disable iff (srst)
        txCount == '0 |=> !txThrHit)
        else $error("tx flag set with empty fifo");

    a_tx_high_hit: assert property (@(posedge sys_clk) disable iff (srst)
        txCount >= `FTC_TX_BASE |=> txThrHit)
        else $error("tx flag missing above highest threshold");
endmodule : ftc_fifo_threshold

// [tb/ftc_host_model.sv]
`timescale 1ns/1ns
module ftc_host_model (
    input wire logic sys_clk,
    output ftc_pkg::ftc_req_t cfgReq,
    output logic sleepExit
);
    import ftc_pkg::*;
    initial begin
        cfgReq = '0;
        sleepExit = 1'b0;
    end
    // Released bus shows inverted values, not the last ones
    task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        cfgReq = '{wr: w, rd: !w, addr: a, data: d};
        @(negedge sys_clk);
        cfgReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask : access
    task automatic wake(input logic keep);
        access(1'b1, 6'h03, {1'b0, keep, 6'h07});
        @(negedge sys_clk);
        sleepExit = 1'b1;
        @(negedge sys_clk);
        sleepExit = 1'b0;
    endtask : wake
endmodule : ftc_host_model

// [tb/ftc_fifo_threshold_test.sv]
`timescale 1ns/1ns
module ftc_fifo_threshold_test;
    import ftc_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    ftc_req_t cfgReq;
    logic sleepExit;
    logic [6:0] rxCount = 7'h00;
    logic [6:0] txCount = 7'h00;
    logic [7:0] rdData;
    ftc_tune_t analogTune;
    logic [4:0] rxAttenDb;
    logic rxThrHit;
    logic txThrHit;
    int seed = 32'h0315;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [7:0] v;
    logic [6:0] rxT;
    logic [6:0] txT;
    ftc_host_model ftc_host_model_i (.sys_clk(sys_clk), .cfgReq(cfgReq), .sleepExit(sleepExit));
    ftc_fifo_threshold ftc_fifo_threshold_i (.sys_clk(sys_clk), .srst(srst), .cfgReq(cfgReq),
        .sleepExit(sleepExit), .rxCount(rxCount), .txCount(txCount), .rdData(rdData),
        .analogTune(analogTune), .rxAttenDb(rxAttenDb), .rxThrHit(rxThrHit),
        .txThrHit(txThrHit));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    initial begin
        repeat (5) @(negedge sys_clk);
        srst = 1'b0;
        ftc_host_model_i.access(1'b0, 6'h03, 8'h00);
        check(rdData, 8'h07);
        ftc_host_model_i.access(1'b0, 6'h3A, 8'h00);
        check(rdData, 8'h00);
        $display("end reset test");
        // First 32 passes sit on and just below each threshold
        for (int i = 0; i < 300; i++) begin
            v = $random(seed);
            if (i < 32)
                v[3:0] = i[4:1];
            rxT = ({3'h0, v[3:0]} + 7'h01) << 2;
            txT = 7'h3D - ({3'h0, v[3:0]} << 2);
            rxCount = (i < 32) ? rxT - i[0] : 7'({$random(seed)} % 65);
            txCount = (i < 32) ? txT - i[0] : 7'({$random(seed)} % 65);
            ftc_host_model_i.access(1'b1, 6'h03, v);
            @(negedge sys_clk);
            check({rxThrHit, txThrHit}, {rxCount >= rxT, txCount >= txT});
            check(rxAttenDb, {3'h0, v[5:4]} * 5'h06);
            ftc_host_model_i.access(1'b0, 6'h03, 8'h00);
            check(rdData, v);
        end
        $display("end threshold test");
        for (int k = 1; k >= 0; k--) begin
            ftc_host_model_i.wake(k[0]);
            check(analogTune, k[0] ? 16'h3581 : 16'h3188);
            ftc_host_model_i.access(1'b0, 6'h2D, 8'h00);
            check(rdData, 8'h31);
            ftc_host_model_i.access(1'b0, 6'h2C, 8'h00);
            check(rdData, 8'h88);
        end
        $display("end wake test");
        stop_test();
    end
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end
endmodule : ftc_fifo_threshold_test
